// File: hw/arlc_pkg.sv
// package: constants for the record adc level control block
package arlc_pkg;
   // ======================================================
   // register byte offsets
   localparam logic [7:0] OFS_CLK_CTRL  = 8'h76;
   localparam logic [7:0] OFS_ADC_CTRL  = 8'h00;
   localparam logic [7:0] OFS_GAIN_L    = 8'h04;
   localparam logic [7:0] OFS_GAIN_R    = 8'h08;
   localparam logic [7:0] OFS_VOL_L     = 8'h0C;
   localparam logic [7:0] OFS_VOL_R     = 8'h10;
   localparam logic [7:0] OFS_LIM_CTRL1 = 8'h14;
   localparam logic [7:0] OFS_LIM_CTRL2 = 8'h18;
   localparam logic [7:0] OFS_LIM_CTRL3 = 8'h1C;
   localparam logic [7:0] OFS_PEAK_L    = 8'h20;
   localparam logic [7:0] OFS_PEAK_R    = 8'h24;
   localparam logic [7:0] OFS_STATUS    = 8'h28;
   // ======================================================
   // field positions
   localparam int BIT_MOD_QUARTER = 0;
   localparam int BIT_LIM_EN      = 0;
   localparam int BIT_LIM_BOTH    = 1;
   localparam int POS_RECOV_MODE  = 2;
   localparam int POS_FAIL_MAX    = 4;
   localparam int POS_ATK_TIME    = 8;
   localparam int POS_REC_TIME    = 12;
   localparam int POS_ATK_THR     = 0;
   localparam int POS_REC_THR     = 16;
   // ======================================================
   // widths and reset values
   localparam int SAMPLE_W = 24;
   localparam int GAIN_W   = 6;
   localparam int MOD_W    = 5;
   localparam logic [GAIN_W-1:0] GAIN_MAX   = 6'h30;
   localparam logic [7:0]        VOL_RESET  = 8'hFF;
   localparam logic [7:0]        CLK_RESET  = 8'h00;
   localparam int MCLK_PER_SAMPLE = 256;
   localparam int SINC_DEC_HALF   = 16;
   localparam int SINC_DEC_QUART  = 8;
   localparam int HB_STAGES       = 3;
   localparam int SINC_ORDER      = 5;
   localparam logic [1:0] REC_NONE    = 2'b00;
   localparam logic [1:0] REC_NORMAL  = 2'b01;
   localparam logic [1:0] REC_LIMITED = 2'b10;
   // interval units in samples
   localparam int TIME_UNIT_SAMPLES = 16;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ATTACK  = 2'b01,
      ST_RECOVER = 2'b11,
      ST_DONE    = 2'b10
   } arlc_state_t;
endpackage

// File: hw/arlc_top.sv
// record adc digital path with automatic gain limiter and wishbone slave
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module arlc_top (
   // system
   input  wire logic                 clk_sys,
   input  wire logic                 srst,
   // wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // modulator side, thermometer codes from pins
   input  wire logic [31:0]          therm_l,
   input  wire logic [31:0]          therm_r,
   // clock steering
   output logic                      mod_clk_en,
   output logic      [1:0]           mclk_source,
   // pga
   output logic      [5:0]           pga_gain_l,
   output logic      [5:0]           pga_gain_r,
   // record output stream
   output logic      [23:0]          sample_l,
   output logic      [23:0]          sample_r,
   output logic                      sample_valid
);
   localparam int SW = arlc_pkg::SAMPLE_W;
   localparam int GW = arlc_pkg::GAIN_W;

   // ======================================================
   // pin synchronisers
   // quantizer codes come from the modulator's own clock
   logic [31:0] th_l_s1_r, th_l_s2_r, th_r_s1_r, th_r_s2_r;
   always_ff @(posedge clk_sys) begin
      th_l_s1_r <= therm_l;
      th_l_s2_r <= th_l_s1_r;
      th_r_s1_r <= therm_r;
      th_r_s2_r <= th_r_s1_r;
   end

   // ======================================================
   // registers
   logic          mod_quarter_r;
   logic [1:0]    clk_src_r;
   logic [GW-1:0] init_l_r, init_r_r;
   logic [7:0]    vol_l_r, vol_r_r;
   logic          lim_en_r, lim_both_r;
   logic [1:0]    rec_mode_r;
   logic [3:0]    fail_max_r, atk_time_r, rec_time_r;
   logic [SW-1:0] atk_thr_r, rec_thr_r;
   logic [SW-1:0] peak_l_r, peak_r_r;

   wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
   wire bus_rd   = bus_req & ~wb_we_i;
   wire settings_open = ~lim_en_r;
   wire wr_clk   = bus_wr & (wb_adr_i == arlc_pkg::OFS_CLK_CTRL);
   wire wr_adc   = bus_wr & (wb_adr_i == arlc_pkg::OFS_ADC_CTRL);
   wire wr_gl    = bus_wr & (wb_adr_i == arlc_pkg::OFS_GAIN_L) & settings_open;
   wire wr_gr    = bus_wr & (wb_adr_i == arlc_pkg::OFS_GAIN_R) & settings_open;
   wire wr_vl    = bus_wr & (wb_adr_i == arlc_pkg::OFS_VOL_L);
   wire wr_vr    = bus_wr & (wb_adr_i == arlc_pkg::OFS_VOL_R);
   wire wr_c1    = bus_wr & (wb_adr_i == arlc_pkg::OFS_LIM_CTRL1);
   wire wr_c2    = bus_wr & (wb_adr_i == arlc_pkg::OFS_LIM_CTRL2)
                   & settings_open;
   wire wr_c3    = bus_wr & (wb_adr_i == arlc_pkg::OFS_LIM_CTRL3);
   wire rd_pk_l  = bus_rd & (wb_adr_i == arlc_pkg::OFS_PEAK_L);
   wire rd_pk_r  = bus_rd & (wb_adr_i == arlc_pkg::OFS_PEAK_R);
   // codes above 24 dB clamp instead of wrapping
   wire [GW-1:0] gain_in = (wb_dat_i[GW-1:0] > arlc_pkg::GAIN_MAX)
                           ? arlc_pkg::GAIN_MAX : wb_dat_i[GW-1:0];
   wire en_bit   = wb_dat_i[arlc_pkg::BIT_LIM_EN];
   // enable bit always writable; other ctrl1 fields only while disabled
   wire lim_fall = wr_c1 & lim_en_r & ~en_bit;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         mod_quarter_r <= 1'b0;
         clk_src_r  <= arlc_pkg::CLK_RESET[1:0];
         init_l_r   <= '0;
         init_r_r   <= '0;
         vol_l_r    <= arlc_pkg::VOL_RESET;
         vol_r_r    <= arlc_pkg::VOL_RESET;
         lim_en_r   <= 1'b0;
         lim_both_r <= 1'b0;
         rec_mode_r <= arlc_pkg::REC_NONE;
         fail_max_r <= '0;
         atk_time_r <= '0;
         rec_time_r <= '0;
         atk_thr_r  <= '1;
         rec_thr_r  <= '0;
      end else begin
         if (wr_clk) clk_src_r <= wb_dat_i[1:0];
         if (wr_adc) mod_quarter_r <= wb_dat_i[arlc_pkg::BIT_MOD_QUARTER];
         if (wr_gl) init_l_r <= gain_in;
         if (wr_gr) init_r_r <= gain_in;
         if (wr_vl) vol_l_r <= wb_dat_i[7:0];
         if (wr_vr) vol_r_r <= wb_dat_i[7:0];
         if (wr_c1) begin
            lim_en_r <= en_bit;
            if (settings_open) begin
               lim_both_r <= wb_dat_i[arlc_pkg::BIT_LIM_BOTH];
               rec_mode_r <= wb_dat_i[arlc_pkg::POS_RECOV_MODE +: 2];
               fail_max_r <= wb_dat_i[arlc_pkg::POS_FAIL_MAX +: 4];
               atk_time_r <= wb_dat_i[arlc_pkg::POS_ATK_TIME +: 4];
               rec_time_r <= wb_dat_i[arlc_pkg::POS_REC_TIME +: 4];
            end
         end
         if (wr_c2) begin
            atk_thr_r <= {wb_dat_i[15:0], 8'h00};
            rec_thr_r <= {wb_dat_i[31:16], 8'h00};
         end
      end
   end

   // ======================================================
   // rate generation: sample every 256 master clocks
   // free running, so sample timing never depends on bus traffic
   logic [7:0] mclk_cnt_r;
   wire mod_tick  = mod_quarter_r ? (mclk_cnt_r[1:0] == 2'b11)
                                  : mclk_cnt_r[0];
   wire samp_tick = (mclk_cnt_r == 8'hFF);
   always_ff @(posedge clk_sys) begin
      if (srst) mclk_cnt_r <= '0;
      else      mclk_cnt_r <= mclk_cnt_r + 8'h01;
   end

   // ======================================================
   // thermometer to binary, then decimation
   function automatic logic [arlc_pkg::MOD_W-1:0] therm2bin(
      input logic [31:0] t);
      logic [arlc_pkg::MOD_W-1:0] n;
      n = '0;
      for (int i = 0; i < 31; i++) n = n + {4'h0, t[i]};
      return n;
   endfunction
   wire [4:0] code_l = therm2bin(th_l_s2_r);
   wire [4:0] code_r = therm2bin(th_r_s2_r);

   // sinc5 (16 or 8) and three half-band /2 stages collapse to one
   // average over 128 or 64 modulator samples; a boxcar keeps area small
   // at the cost of stopband rejection
   logic [11:0] acc_l_r, acc_r_r;
   logic [SW-1:0] raw_l_r, raw_r_r;
   wire [SW-1:0] dec_l = mod_quarter_r
      ? {acc_l_r[10:0], 13'h0000} - 24'h80_0000
      : {acc_l_r[11:0], 12'h000} - 24'h80_0000;
   wire [SW-1:0] dec_r = mod_quarter_r
      ? {acc_r_r[10:0], 13'h0000} - 24'h80_0000
      : {acc_r_r[11:0], 12'h000} - 24'h80_0000;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc_l_r <= '0;
         acc_r_r <= '0;
         raw_l_r <= '0;
         raw_r_r <= '0;
      end else if (samp_tick) begin
         raw_l_r <= dec_l;
         raw_r_r <= dec_r;
         // the window-edge tick seeds the next sum, so none is lost
         acc_l_r <= {7'h00, code_l};
         acc_r_r <= {7'h00, code_r};
      end else if (mod_tick) begin
         acc_l_r <= acc_l_r + {7'h00, code_l};
         acc_r_r <= acc_r_r + {7'h00, code_r};
      end
   end

   // ======================================================
   // volume: 256 linear steps of 1/256 each
   wire [32:0] prod_l = $signed(raw_l_r) * $signed({1'b0, vol_l_r});
   wire [32:0] prod_r = $signed(raw_r_r) * $signed({1'b0, vol_r_r});
   wire [SW-1:0] out_l = prod_l[31:8];
   wire [SW-1:0] out_r = prod_r[31:8];
   wire [SW-1:0] abs_l = raw_l_r[SW-1] ? (~raw_l_r + 24'h00_0001) : raw_l_r;
   wire [SW-1:0] abs_r = raw_r_r[SW-1] ? (~raw_r_r + 24'h00_0001) : raw_r_r;
   // staged one clock after the tick so raw samples have settled
   logic samp_d_r;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         samp_d_r     <= 1'b0;
         sample_l     <= '0;
         sample_r     <= '0;
         sample_valid <= 1'b0;
         peak_l_r     <= '0;
         peak_r_r     <= '0;
      end else begin
         samp_d_r     <= samp_tick;
         sample_valid <= samp_d_r;
         if (samp_d_r) begin
            sample_l <= out_l;
            sample_r <= out_r;
         end
         // new peak wins over clear in the same cycle
         if (samp_d_r && abs_l > peak_l_r) peak_l_r <= abs_l;
         else if (rd_pk_l) peak_l_r <= '0;
         if (samp_d_r && abs_r > peak_r_r) peak_r_r <= abs_r;
         else if (rd_pk_r) peak_r_r <= '0;
      end
   end

   // ======================================================
   // automatic gain limiter
   arlc_pkg::arlc_state_t st_r, st_nxt;
   logic [GW-1:0] offset_r;
   logic [3:0]    fail_cnt_r;
   logic [11:0]   tmr_r;
   logic          rec_exc_r;
   wire over_l = abs_l > atk_thr_r;
   wire over_r = abs_r > atk_thr_r;
   wire over_atk = lim_both_r ? (over_l & over_r)
                              : (over_l | over_r);
   wire over_rec = (abs_l > rec_thr_r) | (abs_r > rec_thr_r);
   wire [GW-1:0] min_init = (init_l_r < init_r_r) ? init_l_r : init_r_r;
   // the smaller channel reaches zero first and stops both
   wire can_drop = offset_r < min_init;
   wire tmr_done = (tmr_r == 12'h000);
   // a disabled limiter is held in reset, so its offset stays zero
   wire lim_reset = wr_c3 | lim_fall | ~lim_en_r;
   // the timer ends at zero, one sample past time*16
   wire [11:0] atk_wait = {4'h0, atk_time_r, 4'h0} + 12'h001;
   wire [11:0] rec_wait = {4'h0, rec_time_r, 4'h0} + 12'h001;
   wire fail_full = (fail_cnt_r >= fail_max_r);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         arlc_pkg::ST_IDLE:
            if (over_atk) st_nxt = arlc_pkg::ST_ATTACK;
         arlc_pkg::ST_ATTACK:
            if (tmr_done && !over_atk)
               st_nxt = (rec_mode_r == arlc_pkg::REC_NONE)
                        ? arlc_pkg::ST_IDLE : arlc_pkg::ST_RECOVER;
         arlc_pkg::ST_RECOVER:
            if (over_atk) st_nxt = arlc_pkg::ST_ATTACK;
            else if (offset_r == '0) st_nxt = arlc_pkg::ST_DONE;
            else if (rec_mode_r == arlc_pkg::REC_LIMITED && fail_full)
               st_nxt = arlc_pkg::ST_DONE;
         arlc_pkg::ST_DONE:
            if (over_atk) st_nxt = arlc_pkg::ST_ATTACK;
         default: st_nxt = arlc_pkg::ST_IDLE;
      endcase
   end

   // one decision per sample keeps the timers in sample units
   always_ff @(posedge clk_sys) begin
      if (srst || lim_reset) begin
         st_r       <= arlc_pkg::ST_IDLE;
         offset_r   <= '0;
         fail_cnt_r <= '0;
         tmr_r      <= '0;
         rec_exc_r  <= 1'b0;
      end else if (samp_d_r) begin
         st_r <= st_nxt;
         if (!tmr_done) tmr_r <= tmr_r - 12'h001;
         case (st_r)
            arlc_pkg::ST_IDLE, arlc_pkg::ST_DONE: begin
               if (over_atk) begin
                  if (can_drop) offset_r <= offset_r + 6'h01;
                  tmr_r      <= atk_wait;
                  fail_cnt_r <= '0;
               end
            end
            arlc_pkg::ST_ATTACK: begin
               if (tmr_done && over_atk) begin
                  if (can_drop) offset_r <= offset_r + 6'h01;
                  tmr_r <= atk_wait;
               end else if (tmr_done) begin
                  tmr_r     <= rec_wait;
                  rec_exc_r <= 1'b0;
               end
            end
            arlc_pkg::ST_RECOVER: begin
               if (over_atk) begin
                  if (can_drop) offset_r <= offset_r + 6'h01;
                  tmr_r      <= atk_wait;
                  fail_cnt_r <= '0;
               end else begin
                  if (over_rec) rec_exc_r <= 1'b1;
                  if (tmr_done) begin
                     tmr_r     <= rec_wait;
                     rec_exc_r <= 1'b0;
                     if (rec_exc_r || over_rec) begin
                        if (rec_mode_r == arlc_pkg::REC_LIMITED && !fail_full)
                           fail_cnt_r <= fail_cnt_r + 4'h1;
                        // held while above recovery level
                     end else if (offset_r != '0) begin
                        offset_r <= offset_r - 6'h01;
                     end
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // ======================================================
   // outputs and bus answer
   // unmapped offsets read zero but are still acknowledged
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (wb_adr_i)
         arlc_pkg::OFS_CLK_CTRL:  rd_mux = {30'h0, clk_src_r};
         arlc_pkg::OFS_ADC_CTRL:  rd_mux = {31'h0, mod_quarter_r};
         arlc_pkg::OFS_GAIN_L:    rd_mux = {26'h0, init_l_r};
         arlc_pkg::OFS_GAIN_R:    rd_mux = {26'h0, init_r_r};
         arlc_pkg::OFS_VOL_L:     rd_mux = {24'h0, vol_l_r};
         arlc_pkg::OFS_VOL_R:     rd_mux = {24'h0, vol_r_r};
         arlc_pkg::OFS_LIM_CTRL1: rd_mux = {16'h0, rec_time_r, atk_time_r,
                                   fail_max_r, rec_mode_r, lim_both_r,
                                   lim_en_r};
         arlc_pkg::OFS_LIM_CTRL2: rd_mux = {rec_thr_r[23:8], atk_thr_r[23:8]};
         arlc_pkg::OFS_PEAK_L:    rd_mux = {8'h0, peak_l_r};
         arlc_pkg::OFS_PEAK_R:    rd_mux = {8'h0, peak_r_r};
         arlc_pkg::OFS_STATUS:    rd_mux = {18'h0, fail_cnt_r, offset_r,
                                   2'b00, st_r};
         default:                 rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wb_ack_o    <= 1'b0;
         wb_dat_o    <= '0;
         mod_clk_en  <= 1'b0;
         mclk_source <= '0;
         pga_gain_l  <= '0;
         pga_gain_r  <= '0;
      end else begin
         wb_ack_o    <= bus_req;
         wb_dat_o    <= bus_rd ? rd_mux : 32'h0000_0000;
         mod_clk_en  <= mod_tick;
         mclk_source <= clk_src_r;
         // offset never passes the smaller initial gain: no underflow
         pga_gain_l  <= init_l_r - offset_r;
         pga_gain_r  <= init_r_r - offset_r;
      end
   end
endmodule
`default_nettype wire

// File: verif/arlc_front_model.sv
// behavioural record front end: input level to thermometer code
`timescale 1ns/1ns
`default_nettype none
module arlc_front_model (
   // system
   input  wire logic        clk_sys,
   // commanded levels, 0 to 31
   input  wire logic [4:0]  level_l,
   input  wire logic [4:0]  level_r,
   // flash outputs
   output logic      [31:0] therm_l,
   output logic      [31:0] therm_r
);
   logic spare_r = 1'b0;
   // unused top line wiggles so nothing leans on it
   always_ff @(posedge clk_sys) begin
      spare_r <= ~spare_r;
   end
   // level k lights the k lowest comparators
   assign therm_l = {spare_r, 31'(~(32'hFFFF_FFFF << level_l))};
   assign therm_r = {~spare_r, 31'(~(32'hFFFF_FFFF << level_r))};
endmodule
`default_nettype wire

// File: verif/arlc_props.sv
// checker: bus, stream and gain relations seen at the block's ports
`timescale 1ns/1ns
`default_nettype none
module arlc_props (
   // system and wishbone
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // datapath
   input wire logic        mod_clk_en,
   input wire logic [1:0]  mclk_source,
   input wire logic [5:0]  pga_gain_l,
   input wire logic [23:0] sample_l,
   input wire logic        sample_valid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   logic [8:0] vcnt_r;
   logic       seen_r;
   logic [9:0] wcnt_r;
   logic [1:0] src_r;
   wire        wr_ack;
   wire        src_wr;
   assign wr_ack = wb_ack_o && wb_we_i;
   assign src_wr = wr_ack && wb_adr_i == arlc_pkg::OFS_CLK_CTRL;
   // =========================================================
   // helpers; write guard spans a limiter reset landing late
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         vcnt_r <= 9'h000;
         seen_r <= 1'b0;
         wcnt_r <= 10'h000;
         src_r  <= 2'h0;
      end else begin
         vcnt_r <= sample_valid ? 9'h001 : vcnt_r + 9'h001;
         seen_r <= seen_r | sample_valid;
         wcnt_r <= wr_ack ? 10'h000 : wcnt_r + {9'h000, ~&wcnt_r};
         src_r  <= src_wr ? wb_dat_i[1:0] : src_r;
      end
   end
   // =========================================================
   // assertions
   a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   a_modclk_gap: assert property (mod_clk_en |=> !mod_clk_en)
      else $error("modulator enable on two cycles in a row");
   a_valid_period: assert property (
      sample_valid && seen_r |-> vcnt_r == 9'h100)
      else $error("sample spacing not 256 clocks");
   a_valid_gap: assert property (seen_r |-> vcnt_r <= 9'h100)
      else $error("sample pulse overdue");
   a_sample_hold: assert property (
      $changed(sample_l) |-> sample_valid)
      else $error("sample changed without valid");
   a_gain_ceiling: assert property (pga_gain_l <= arlc_pkg::GAIN_MAX)
      else $error("gain above 24 dB");
   a_gain_step: assert property (
      &wcnt_r[9:8] && $changed(pga_gain_l) |->
      pga_gain_l == $past(pga_gain_l) + 7'h01 ||
      pga_gain_l + 7'h01 == $past(pga_gain_l))
      else $error("gain moved by more than one step");
   a_clk_source: assert property (
      src_wr |=> ##[0:1] mclk_source == src_r)
      else $error("clock source does not follow register");
endmodule
bind arlc_top arlc_props u_props (
   .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .mod_clk_en(mod_clk_en), .mclk_source(mclk_source),
   .pga_gain_l(pga_gain_l), .sample_l(sample_l),
   .sample_valid(sample_valid)
);
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the record level control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   typedef struct {logic [7:0] adr, wd, ex;} arlc_row_t;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o, therm_l, therm_r, rd;
   logic        wb_ack_o, mod_clk_en, sample_valid;
   logic [1:0]  mclk_source;
   logic [5:0]  pga_gain_l, pga_gain_r;
   logic [23:0] sample_l, sample_r;
   logic [4:0]  level_l = 5'h10;
   logic [4:0]  level_r = 5'h10;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          k, pulses;
   logic [31:0] vl, vr;
   arlc_row_t   rows [8] = '{
      '{arlc_pkg::OFS_VOL_L, 8'h80, 8'h80},
      '{arlc_pkg::OFS_VOL_L, 8'hFF, 8'hFF},
      '{arlc_pkg::OFS_VOL_R, 8'hFF, 8'hFF},
      '{arlc_pkg::OFS_GAIN_L, 8'h3F, 8'h30},
      '{arlc_pkg::OFS_GAIN_L, 8'h20, 8'h20},
      '{arlc_pkg::OFS_GAIN_R, 8'h10, 8'h10},
      '{arlc_pkg::OFS_CLK_CTRL, 8'h02, 8'h02},
      '{8'h40, 8'h55, 8'h00}};
   always #50 clk_sys = ~clk_sys;
   arlc_top uut (
      .clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .therm_l(therm_l), .therm_r(therm_r),
      .mod_clk_en(mod_clk_en), .mclk_source(mclk_source),
      .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r),
      .sample_l(sample_l), .sample_r(sample_r),
      .sample_valid(sample_valid));
   arlc_front_model u_front (
      .clk_sys(clk_sys), .level_l(level_l), .level_r(level_r),
      .therm_l(therm_l), .therm_r(therm_r));
   // =========================================================
   // tasks
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      cmp_count++;
      if (got !== ex) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, ex);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      wb(1'b0, a, 32'h0000_0000);
   endtask
   // toggling enable off first also restarts the limiter
   task automatic lim(input logic [15:0] c1);
      wb(1'b1, arlc_pkg::OFS_LIM_CTRL1, 32'h0000_0000);
      wb(1'b1, arlc_pkg::OFS_LIM_CTRL1, {16'h0000, c1});
   endtask
   task automatic run(input logic [4:0] l, r, input int n,
                      input logic [5:0] gl, gr);
      level_l <= l;
      level_r <= r;
      repeat (n * 256) @(posedge clk_sys);
      chk({26'h000_0000, pga_gain_l}, {26'h000_0000, gl});
      chk({26'h000_0000, pga_gain_r}, {26'h000_0000, gr});
   endtask
   // =========================================================
   // watchdog and main sequence
   initial begin
      repeat (90000) @(posedge clk_sys);
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      rdr(arlc_pkg::OFS_VOL_L);
      chk(rd, 32'h0000_00FF);
      rdr(arlc_pkg::OFS_LIM_CTRL1);
      chk(rd, 32'h0000_0000);
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, {24'h00_0000, rows[i].wd});
         rdr(rows[i].adr);
         chk(rd, {24'h00_0000, rows[i].ex});
      end
      chk({30'h0000_0000, mclk_source}, 32'h0000_0002);
      for (k = 1; k >= 0; k--) begin
         wb(1'b1, arlc_pkg::OFS_ADC_CTRL, k);
         repeat (4) @(posedge clk_sys);
         pulses = 0;
         repeat (64) begin
            @(posedge clk_sys);
            if (mod_clk_en === 1'b1) pulses++;
         end
         chk(pulses, 32 >> k);
      end
      wb(1'b1, arlc_pkg::OFS_LIM_CTRL2, 32'h1000_6000);
      lim(16'h0003);
      run(5'h1F, 5'h10, 20, 6'h20, 6'h10);
      lim(16'h0001);
      run(5'h1F, 5'h10, 40, 6'h10, 6'h00);
      wb(1'b1, arlc_pkg::OFS_GAIN_L, 32'h0000_0005);
      rdr(arlc_pkg::OFS_GAIN_L);
      chk(rd, 32'h0000_0020);
      run(5'h10, 5'h10, 20, 6'h10, 6'h00);
      wb(1'b1, arlc_pkg::OFS_LIM_CTRL3, 32'h0000_0000);
      run(5'h10, 5'h10, 4, 6'h20, 6'h10);
      lim(16'h0005);
      run(5'h1F, 5'h1F, 40, 6'h10, 6'h00);
      run(5'h18, 5'h18, 10, 6'h10, 6'h00);
      run(5'h10, 5'h10, 40, 6'h20, 6'h10);
      lim(16'h0039);
      run(5'h1F, 5'h1F, 40, 6'h10, 6'h00);
      run(5'h18, 5'h18, 20, 6'h10, 6'h00);
      rdr(arlc_pkg::OFS_STATUS);
      chk({28'h000_0000, rd[13:10]}, 32'h0000_0003);
      run(5'h10, 5'h10, 20, 6'h10, 6'h00);
      run(5'h1F, 5'h1F, 4, 6'h10, 6'h00);
      rdr(arlc_pkg::OFS_STATUS);
      chk({28'h000_0000, rd[13:10]}, 32'h0000_0000);
      @(posedge sample_valid);
      rdr(arlc_pkg::OFS_PEAK_L);
      chk({31'h0000_0000, |rd}, 32'h0000_0001);
      rdr(arlc_pkg::OFS_PEAK_L);
      chk(rd, 32'h0000_0000);
      wb(1'b1, arlc_pkg::OFS_VOL_R, 32'h0000_0080);
      repeat (2) @(posedge sample_valid);
      @(posedge clk_sys);
      vl = {8'h00, sample_l};
      vr = {7'h00, sample_r, 1'b0};
      chk({31'h0000_0000, ~vl[23] & |vl[22:0]}, 32'h0000_0001);
      k = int'(vr > vl - (vl >> 6) && vr < vl + (vl >> 6));
      chk(k, 32'h0000_0001);
      complete_run();
   end
endmodule
`default_nettype wire
